// ==== verilog/switch_qos_pkg.sv ====
// Constants shared by the switch port QoS, tagging and spanning-tree logic
package switch_qos_pkg;

	// ****************************************
	// Port control register map (port 1..3)
	// ****************************************
	localparam logic [7:0] PORT1_CTRL0_ADDR = 8'h10;
	localparam logic [7:0] PORT2_CTRL0_ADDR = 8'h20;
	localparam logic [7:0] PORT3_CTRL0_ADDR = 8'h30;
	localparam logic [7:0] PRIO_MAP_ADDR    = 8'h0c;
	localparam logic [7:0] STP_P1_ADDR      = 8'h12;
	localparam logic [7:0] STP_P2_ADDR      = 8'h22;
	localparam logic [7:0] INSERT_SEL_ADDR  = 8'hc2;
	localparam logic [7:0] DSCP_MAP_ADDR    = 8'h60;

	// ****************************************
	// Field positions in port control 0
	// ****************************************
	localparam int CTRL_SPLIT_BIT  = 0;
	localparam int CTRL_REMOVE_BIT = 1;
	localparam int CTRL_INSERT_BIT = 2;
	localparam int CTRL_PORTPRI_LO = 3;
	localparam int CTRL_PORTPRI_HI = 4;
	localparam int CTRL_DOT1P_BIT  = 5;

	// ****************************************
	// Spanning-tree control field positions
	// ****************************************
	localparam int STP_LEARN_DIS_BIT = 0;
	localparam int STP_RX_EN_BIT     = 1;
	localparam int STP_TX_EN_BIT     = 2;

	// ****************************************
	// Frame layout and checksum
	// ****************************************
	localparam logic [15:0] VLAN_TPID    = 16'h8100;
	localparam logic [3:0]  HDR_LAST_IDX = 4'hb;
	localparam logic [3:0]  TAG_LAST_IDX = 4'h3;
	localparam logic [31:0] CRC_INIT     = 32'hffffffff;
	localparam logic [31:0] CRC_POLY     = 32'hedb88320;

	// ****************************************
	// Priorities and ports
	// ****************************************
	localparam logic [1:0] PRIO_HIGH = 2'h3;
	localparam logic [1:0] PRIO_LOW  = 2'h0;
	localparam int         PROC_PORT = 2;
	localparam logic [2:0] PROC_MASK = 3'h4;

	// Egress stream editor states
	typedef enum logic [2:0] {E_IDLE, E_HDR, E_TAG, E_SKIP, E_BODY, E_FCS} egr_state_t;

endpackage

// ==== verilog/switch_port_qos_tagging_stp.sv ====
// Ingress classification, spanning-tree filtering and egress VLAN tag editor
`timescale 1ns/1ns
// Overview of operation
// - Port-based priority marks every received frame high, using high queue when split.
// - Port-based priority enabled by control 0 bits 4:3 of each port.
// - Tagged frames: three-bit user priority mapped through the programmable priority map.
// - 802.1p classification enabled per port by control 0 bit 5.
// - The inserted or stripped tag is four bytes: TPID then TCI.
// - Insertion enabled by control 0 bit 2 plus the source-select field.
// - Untagged frames get their ingress port's default tag when inserting.
// - Source default tag inserted only when its select bit is set.
// - Already tagged frames are never tagged twice; their tag is kept.
// - Removal enabled by control 0 bit 1 strips tags from tagged frames.
// - With removal enabled and insertion off, untagged frames pass unmodified.
// - Frame check sequence is recomputed over the edited frame.
// - Re-mapping caps frame priority at the ingress default tag priority.
// - IP frames: six-bit code point selects priority from the code-point map.
// - Port 3 is the processor port; only ports 1 and 2 have tree state.
// - Tree state per port from transmit enable, receive enable, learning disable.
// - Disable state: no forwarding, no receiving, no learning.
// - Blocking: forward only frames to the processor, learning off.
// - Listening and learning: only processor traffic; learning off, then on.
// - Forwarding state: forward, receive and learn normally.
// - Static entries with override still reach the processor in disable state.
// - Transmit queue split into four priorities only when control 0 bit 0 set.
module switch_port_qos_tagging_stp
(
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Configuration
	input  wire logic [2:0][7:0]    portCtrl0,
	input  wire logic [15:0]        prioMap,
	input  wire logic [2:0][15:0]   portDefaultTag,
	input  wire logic [5:0]         insertSel,
	input  wire logic [127:0]       dscpMap,
	input  wire logic [2:0]         dscpEn,
	input  wire logic [2:0]         remapEn,
	input  wire logic [1:0][2:0]    stpCtrl,
	// Ingress frame descriptor
	input  wire logic               ingValid,
	input  wire logic [1:0]         ingPort,
	input  wire logic               ingTagged,
	input  wire logic [2:0]         ingPcp,
	input  wire logic               ingIsIp,
	input  wire logic [5:0]         ingDscp,
	input  wire logic [2:0]         ingDstMask,
	input  wire logic               ingStaticOverride,
	// Classification result
	output logic                    clsValid_q,
	output logic [1:0]              clsPrio_q,
	output logic [2:0]              clsPcp_q,
	output logic [2:0]              clsFwdMask_q,
	output logic [2:0][1:0]         clsQueue_q,
	output logic                    clsLearn_q,
	// Egress byte stream in
	input  wire logic [1:0]         egressPort,
	input  wire logic               egrValid,
	input  wire logic [7:0]         egrData,
	input  wire logic               egrLast,
	input  wire logic               egrTagged,
	input  wire logic [1:0]         egrSrcPort,
	output logic                    egrReady,
	// Egress byte stream out
	output logic                    txValid_q,
	output logic [7:0]              txData_q,
	output logic                    txLast_q,
	input  wire logic               txReady
);
	import switch_qos_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	// Reflected CRC-32, one byte per call
	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h000000, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
	// Select bit for source port s at egress port e: two bits per egress port
	function automatic logic insertAllowed(input logic [1:0] e, s, input logic [5:0] sel);
		logic [1:0] slot;
		slot = (s < e) ? s[1:0] : 2'(s - 2'h1);
		return sel[{e[1:0], slot[0]}];
	endfunction
	// ****************************************
	// Ingress classification and tree filtering
	// ****************************************
	logic              clsValid_d;
	logic [1:0]        clsPrio_d;
	logic [2:0]        clsPcp_d;
	logic [2:0]        clsFwdMask_d;
	logic [2:0][1:0]   clsQueue_d;
	logic              clsLearn_d;

	// Descriptor arrives once per frame, so settings are sampled per frame
	always_comb
	begin
		logic [7:0] ctrl;
		logic [2:0] st;
		logic [2:0] capPcp;
		ctrl = portCtrl0[ingPort];
		st = 3'h0;
		capPcp = portDefaultTag[ingPort][15:13];
		clsValid_d = ingValid;
		clsPcp_d = ingPcp;
		clsFwdMask_d = ingDstMask;
		clsLearn_d = 1'b1;
		// Port-based wins, then tag, then code point
		if (ctrl[CTRL_PORTPRI_HI:CTRL_PORTPRI_LO] != 2'h0)
			clsPrio_d = PRIO_HIGH;
		else if (ctrl[CTRL_DOT1P_BIT] && ingTagged)
			clsPrio_d = prioMap[{ingPcp, 1'b0} +: 2];
		else if (dscpEn[ingPort] && ingIsIp)
			clsPrio_d = dscpMap[{ingDscp, 1'b0} +: 2];
		else
			clsPrio_d = PRIO_LOW;
		// Priority ceiling from the ingress default tag
		if (remapEn[ingPort] && ingTagged && ingPcp > capPcp)
			clsPcp_d = capPcp;
		// Processor port has no tree state
		if (ingPort != 2'(PROC_PORT))
		begin
			st = stpCtrl[ingPort[0]];
			clsLearn_d = !st[STP_LEARN_DIS_BIT];
			if (!st[STP_RX_EN_BIT])
			begin
				// Non-forwarding states reach the processor only
				clsFwdMask_d = ingDstMask & PROC_MASK;
				if (st[STP_LEARN_DIS_BIT])
					clsFwdMask_d = ingStaticOverride ? PROC_MASK : 3'h0;
			end
		end
		// Closed transmit side keeps port traffic out; processor only in the off states
		for (int q = 0; q < 2; q++)
		begin
			if (ingPort != 2'(PROC_PORT) && !stpCtrl[q][STP_TX_EN_BIT])
				clsFwdMask_d[q] = 1'b0;
			else if (!stpCtrl[q][STP_TX_EN_BIT] && stpCtrl[q][STP_LEARN_DIS_BIT])
				clsFwdMask_d[q] = 1'b0;
		end
		// Queue per destination, shared queue when not split
		for (int d = 0; d < 3; d++)
		begin
			clsQueue_d[d] = portCtrl0[d][CTRL_SPLIT_BIT] ? clsPrio_d : PRIO_LOW;
		end
	end
	// Classification result registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			clsValid_q   <= 1'b0;
			clsPrio_q    <= PRIO_LOW;
			clsPcp_q     <= 3'h0;
			clsFwdMask_q <= 3'h0;
			clsQueue_q   <= '0;
			clsLearn_q   <= 1'b0;
		end
		else
		begin
			clsValid_q   <= clsValid_d;
			clsPrio_q    <= clsPrio_d;
			clsPcp_q     <= clsPcp_d;
			clsFwdMask_q <= clsFwdMask_d;
			clsQueue_q   <= clsQueue_d;
			clsLearn_q   <= clsLearn_d;
		end
	end
	// ****************************************
	// Egress tag editor
	// ****************************************
	egr_state_t  state_q, state_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [31:0] crc_q, crc_d;
	logic        ins_q, ins_d;
	logic        rem_q, rem_d;
	logic [15:0] tci_q, tci_d;
	logic        txValid_d;
	logic [7:0]  txData_d;
	logic        txLast_d;
	logic        adv;
	// Output stage may load when empty or being drained
	assign adv = !txValid_q || txReady;
	// Next-state, byte selection and checksum update
	always_comb
	begin
		logic        emit;
		logic [7:0]  b;
		logic        last;
		logic [31:0] w;
		logic [7:0]  e;
		emit = 1'b0;
		b = 8'h00;
		last = 1'b0;
		w = 32'h00000000;
		e = portCtrl0[egressPort];
		state_d = state_q;
		cnt_d = cnt_q;
		crc_d = crc_q;
		ins_d = ins_q;
		rem_d = rem_q;
		tci_d = tci_q;
		egrReady = 1'b0;
		unique case (state_q)
			E_IDLE:
			begin
				// Settings frozen at first byte for the whole frame
				ins_d = e[CTRL_INSERT_BIT] && !egrTagged
					&& insertAllowed(egressPort, egrSrcPort, insertSel);
				rem_d = e[CTRL_REMOVE_BIT] && egrTagged;
				tci_d = portDefaultTag[egrSrcPort];
				if (egrValid && adv)
				begin
					egrReady = 1'b1;
					emit = 1'b1;
					b = egrData;
					cnt_d = 4'h1;
					crc_d = crcByte(CRC_INIT, egrData);
					state_d = E_HDR;
				end
			end
			E_HDR:
			begin
				if (egrValid && adv)
				begin
					egrReady = 1'b1;
					emit = 1'b1;
					b = egrData;
					crc_d = crcByte(crc_q, egrData);
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == HDR_LAST_IDX)
					begin
						cnt_d = 4'h0;
						state_d = ins_q ? E_TAG : (rem_q ? E_SKIP : E_BODY);
					end
				end
			end
			E_TAG:
			begin
				// Input stalls while the four tag bytes go out
				w = {VLAN_TPID, tci_q} << {cnt_q[1:0], 3'b000};
				if (adv)
				begin
					emit = 1'b1;
					b = w[31:24];
					crc_d = crcByte(crc_q, w[31:24]);
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == TAG_LAST_IDX)
						state_d = E_BODY;
				end
			end
			E_SKIP:
			begin
				// Old tag bytes consumed without output
				egrReady = 1'b1;
				if (egrValid)
				begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == TAG_LAST_IDX)
						state_d = E_BODY;
				end
			end
			E_BODY:
			begin
				if (egrValid && adv)
				begin
					egrReady = 1'b1;
					emit = 1'b1;
					b = egrData;
					crc_d = crcByte(crc_q, egrData);
					if (egrLast)
					begin
						cnt_d = 4'h0;
						state_d = E_FCS;
					end
				end
			end
			E_FCS:
			begin
				// Fresh checksum over exactly the bytes sent
				w = ~crc_q >> {cnt_q[1:0], 3'b000};
				if (adv)
				begin
					emit = 1'b1;
					b = w[7:0];
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == TAG_LAST_IDX)
					begin
						last = 1'b1;
						state_d = E_IDLE;
					end
				end
			end
		endcase
		// Output register load or drain
		txValid_d = emit ? 1'b1 : (txReady ? 1'b0 : txValid_q);
		txData_d = emit ? b : txData_q;
		txLast_d = emit ? last : txLast_q;
	end
	// Egress registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_q   <= E_IDLE;
			cnt_q     <= 4'h0;
			crc_q     <= CRC_INIT;
			ins_q     <= 1'b0;
			rem_q     <= 1'b0;
			tci_q     <= 16'h0000;
			txValid_q <= 1'b0;
			txData_q  <= 8'h00;
			txLast_q  <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			crc_q     <= crc_d;
			ins_q     <= ins_d;
			rem_q     <= rem_d;
			tci_q     <= tci_d;
			txValid_q <= txValid_d;
			txData_q  <= txData_d;
			txLast_q  <= txLast_d;
		end
	end
endmodule

// ==== verif/switch_port_qos_tagging_stp_chk.sv ====
// Concurrent checks on the classification outputs
`timescale 1ns/1ns
module switch_port_qos_tagging_stp_chk
(
	// Clock and reset
	input wire logic            ref_clk,
	input wire logic            rst_n,
	// Configuration
	input wire logic [2:0][7:0] portCtrl0,
	input wire logic [15:0]     prioMap,
	input wire logic [2:0][15:0] portDefaultTag,
	input wire logic [127:0]    dscpMap,
	input wire logic [2:0]      dscpEn,
	input wire logic [2:0]      remapEn,
	input wire logic [1:0][2:0] stpCtrl,
	// Ingress descriptor
	input wire logic            ingValid,
	input wire logic [1:0]      ingPort,
	input wire logic            ingTagged,
	input wire logic [2:0]      ingPcp,
	input wire logic            ingIsIp,
	input wire logic [5:0]      ingDscp,
	input wire logic            ingStaticOverride,
	// Classification result
	input wire logic            clsValid_q,
	input wire logic [1:0]      clsPrio_q,
	input wire logic [2:0]      clsPcp_q,
	input wire logic [2:0]      clsFwdMask_q,
	input wire logic [2:0][1:0] clsQueue_q,
	input wire logic            clsLearn_q
);
	// ********************************
	// Classification properties
	// ********************************
	// One clock domain, so clocking and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_cls_latency: assert property (ingValid |=> clsValid_q)
		else $error("classification result missing one cycle after request");
	a_port_prio: assert property (ingValid && portCtrl0[ingPort][4:3] != 2'h0
		|=> clsPrio_q == 2'h3)
		else $error("port priority not high");
	a_dot1p_map: assert property (ingValid && portCtrl0[ingPort][5:3] == 3'h4
		&& ingTagged && !remapEn[ingPort]
		|=> clsPrio_q == $past(prioMap[{ingPcp, 1'b0} +: 2]))
		else $error("user priority mapping wrong");
	a_dscp_map: assert property (ingValid && portCtrl0[ingPort][5:3] == 3'h0
		&& dscpEn[ingPort] && ingIsIp
		|=> clsPrio_q == $past(dscpMap[{ingDscp, 1'b0} +: 2]))
		else $error("code point mapping wrong");
	a_queue_split: assert property (clsValid_q |->
		clsQueue_q[0] == ($past(portCtrl0[0][0]) ? clsPrio_q : 2'h0)
		&& clsQueue_q[1] == ($past(portCtrl0[1][0]) ? clsPrio_q : 2'h0)
		&& clsQueue_q[2] == ($past(portCtrl0[2][0]) ? clsPrio_q : 2'h0))
		else $error("queue index disagrees with split setting");
	a_disable_drop: assert property (ingValid && ingPort != 2'h2
		&& stpCtrl[ingPort[0]] == 3'h1 && !ingStaticOverride
		|=> clsFwdMask_q == 3'h0 && !clsLearn_q)
		else $error("disabled port still forwards or learns");
	a_override_cpu: assert property (ingValid && ingPort != 2'h2
		&& stpCtrl[ingPort[0]] == 3'h1 && ingStaticOverride
		|=> clsFwdMask_q == 3'h4)
		else $error("override frame not sent to processor");
	a_pcp_ceiling: assert property (ingValid && remapEn[ingPort] && ingTagged
		|=> clsPcp_q <= $past(portDefaultTag[ingPort][15:13]))
		else $error("priority above ceiling");
endmodule

bind switch_port_qos_tagging_stp switch_port_qos_tagging_stp_chk uChk (.ref_clk(ref_clk),
	.rst_n(rst_n), .portCtrl0(portCtrl0), .prioMap(prioMap), .portDefaultTag(portDefaultTag),
	.dscpMap(dscpMap), .dscpEn(dscpEn), .remapEn(remapEn), .stpCtrl(stpCtrl),
	.ingValid(ingValid), .ingPort(ingPort), .ingTagged(ingTagged), .ingPcp(ingPcp),
	.ingIsIp(ingIsIp), .ingDscp(ingDscp), .ingStaticOverride(ingStaticOverride),
	.clsValid_q(clsValid_q), .clsPrio_q(clsPrio_q), .clsPcp_q(clsPcp_q),
	.clsFwdMask_q(clsFwdMask_q), .clsQueue_q(clsQueue_q), .clsLearn_q(clsLearn_q));

// ==== verif/tx_sink_model.sv ====
// Downstream sink for the egress stream, with optional stalls
`timescale 1ns/1ns
module tx_sink_model
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Stall control
	input wire logic       slow,
	// Egress stream
	input wire logic       txValid_q,
	input wire logic [7:0] txData_q,
	input wire logic       txLast_q,
	output logic           txReady
);
	logic [8:0] got [$];
	logic [1:0] phase = 2'h0;

	// ********************************
	// Capture and stall
	// ********************************
	// Stall one cycle in three when slow, so held output bytes get exercised
	always @(posedge ref_clk)
	begin
		if (rst_n && txValid_q && txReady)
			got.push_back({txLast_q, txData_q});
		phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
		txReady <= rst_n && !(slow && phase == 2'h2);
	end
endmodule

// ==== verif/switch_port_qos_tagging_stp_tb.sv ====
// Self-checking bench for port classification, tree state and tag editing
`timescale 1ns/1ns
module switch_port_qos_tagging_stp_tb;
	import switch_qos_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0][7:0] portCtrl0 = 24'h010821;
	logic [15:0] prioMap = 16'h1be4;
	logic [2:0][15:0] portDefaultTag = 48'h4003_0000_4005;
	logic [5:0] insertSel = 6'h0;
	logic [127:0] dscpMap = 128'h0;
	logic [2:0] dscpEn = 3'h4;
	logic [2:0] remapEn = 3'h0;
	logic [1:0][2:0] stpCtrl = 6'h36;
	logic ingValid = 1'b0, ingTagged = 1'b0, ingIsIp = 1'b0, ingStaticOverride = 1'b0;
	logic [1:0] ingPort = 2'h0;
	logic [2:0] ingPcp = 3'h0, ingDstMask = 3'h0;
	logic [5:0] ingDscp = 6'h0;
	logic egrValid = 1'b0, egrLast = 1'b0, egrTagged = 1'b0, slow = 1'b0;
	logic [7:0] egrData = 8'h0;
	logic [1:0] egrSrc = 2'h0;
	logic clsValid_q, clsLearn_q, egrReady, txValid_q, txLast_q, txReady;
	logic [1:0] clsPrio_q;
	logic [2:0] clsPcp_q, clsFwdMask_q;
	logic [2:0][1:0] clsQueue_q;
	logic [7:0] txData_q;
	logic [7:0] frm [$];
	logic [7:0] expBytes [$];
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;

	switch_port_qos_tagging_stp dut (.ref_clk(ref_clk), .rst_n(rst_n), .portCtrl0(portCtrl0),
		.prioMap(prioMap), .portDefaultTag(portDefaultTag), .insertSel(insertSel),
		.dscpMap(dscpMap), .dscpEn(dscpEn), .remapEn(remapEn), .stpCtrl(stpCtrl),
		.ingValid(ingValid), .ingPort(ingPort), .ingTagged(ingTagged), .ingPcp(ingPcp),
		.ingIsIp(ingIsIp), .ingDscp(ingDscp), .ingDstMask(ingDstMask),
		.ingStaticOverride(ingStaticOverride), .clsValid_q(clsValid_q), .clsPrio_q(clsPrio_q),
		.clsPcp_q(clsPcp_q), .clsFwdMask_q(clsFwdMask_q), .clsQueue_q(clsQueue_q),
		.clsLearn_q(clsLearn_q), .egressPort(2'h1), .egrValid(egrValid), .egrData(egrData),
		.egrLast(egrLast), .egrTagged(egrTagged), .egrSrcPort(egrSrc), .egrReady(egrReady),
		.txValid_q(txValid_q), .txData_q(txData_q), .txLast_q(txLast_q), .txReady(txReady));
	tx_sink_model sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .txValid_q(txValid_q),
		.txData_q(txData_q), .txLast_q(txLast_q), .txReady(txReady));

	// ********************************
	// Tasks
	// ********************************
	initial
		forever #5 ref_clk = ~ref_clk;

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
		n_compared++;
		if (got !== want)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %0h want %0h", $time, msg, got, want);
		end
	endtask

	// One descriptor, result checked one cycle later
	task automatic cls(input logic [1:0] p, input logic t, input logic [2:0] pcp, input logic ip,
		input logic [5:0] cp, input logic [2:0] dst, input logic ovr, input logic [1:0] ePrio,
		input logic [2:0] eMask, input logic eLearn);
		@(posedge ref_clk);
		ingValid <= 1'b1;
		{ingPort, ingTagged, ingPcp, ingIsIp, ingDscp, ingDstMask, ingStaticOverride}
			<= {p, t, pcp, ip, cp, dst, ovr};
		@(posedge ref_clk);
		ingValid <= 1'b0;
		#1;
		chk(clsValid_q, 1'b1, "valid");
		chk(clsPrio_q, ePrio, "prio");
		chk(clsFwdMask_q, eMask, "mask");
		chk(clsLearn_q, eLearn, "learn");
		for (int d = 0; d < 3; d++)
			chk(clsQueue_q[d], portCtrl0[d][0] ? ePrio : 2'h0, "queue");
	endtask

	// One frame through the port 2 editor from source port src
	task automatic egress(input logic [1:0] src, input logic ins, input logic rem,
		input logic sel, input logic tg);
		logic [31:0] crc;
		frm = {};
		for (int i = 0; i < 12; i++)
			frm.push_back(8'(i + 1));
		if (tg)
			frm = {frm, 8'h81, 8'h00, 8'ha0, 8'h07};
		for (int i = 0; i < 4; i++)
			frm.push_back(8'(8'h50 + i));
		expBytes = frm;
		if (ins && sel && !tg)
			expBytes = {frm[0:11], 8'h81, 8'h00, portDefaultTag[src][15:8],
				portDefaultTag[src][7:0], frm[12:15]};
		if (rem && tg)
			expBytes = {frm[0:11], frm[16:19]};
		crc = CRC_INIT;
		foreach (expBytes[i])
		begin
			crc ^= {24'h0, expBytes[i]};
			repeat (8)
				crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
		end
		crc = ~crc;
		expBytes = {expBytes, crc[7:0], crc[15:8], crc[23:16], crc[31:24]};
		@(posedge ref_clk);
		portCtrl0[1] <= {3'h0, 2'h1, ins, rem, 1'b0};
		insertSel <= sel ? (src == 2'h0 ? 6'h04 : 6'h08) : 6'h00;
		egrSrc <= src;
		sink.got = {};
		foreach (frm[i])
		begin
			{egrValid, egrData, egrLast, egrTagged} <= {1'b1, frm[i], i == frm.size() - 1, tg};
			@(posedge ref_clk);
			for (int w = 0; w < 50 && egrReady !== 1'b1; w++)
				@(posedge ref_clk);
		end
		egrValid <= 1'b0;
		for (int w = 0; w < 200 && sink.got.size() < expBytes.size(); w++)
			@(posedge ref_clk);
		chk(sink.got.size(), expBytes.size(), "length");
		foreach (expBytes[i])
			if (i < sink.got.size())
				chk(sink.got[i], {i == expBytes.size() - 1, expBytes[i]}, "byte");
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			err_count++;
			$display("[FAIL] %0t run did not finish", $time);
			test_done();
		end
	end

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		for (int c = 0; c < 64; c++)
			dscpMap[2 * c +: 2] = 2'(c ^ (c >> 4));
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int p = 0; p < 8; p++)
			cls(2'h0, 1'b1, 3'(p), 1'b0, 6'h0, 3'h6, 1'b0, prioMap[2 * p +: 2], 3'h6, 1'b1);
		cls(2'h0, 1'b0, 3'h7, 1'b0, 6'h0, 3'h6, 1'b0, 2'h0, 3'h6, 1'b1);
		for (int c = 0; c < 64; c++)
			cls(2'h2, 1'b0, 3'h0, 1'b1, 6'(c), 3'h3, 1'b0, 2'(c ^ (c >> 4)), 3'h3, 1'b1);
		cls(2'h2, 1'b0, 3'h0, 1'b0, 6'h3f, 3'h3, 1'b0, 2'h0, 3'h3, 1'b1);
		cls(2'h1, 1'b1, 3'h0, 1'b1, 6'h0, 3'h5, 1'b0, 2'h3, 3'h5, 1'b1);
		@(posedge ref_clk);
		remapEn <= 3'h4;
		cls(2'h2, 1'b1, 3'h7, 1'b0, 6'h0, 3'h3, 1'b0, 2'h0, 3'h3, 1'b1);
		chk(clsPcp_q, 3'h2, "ceiling");
		cls(2'h2, 1'b1, 3'h1, 1'b0, 6'h0, 3'h3, 1'b0, 2'h0, 3'h3, 1'b1);
		chk(clsPcp_q, 3'h1, "below ceiling");
		@(posedge ref_clk);
		stpCtrl[0] <= 3'h1;
		cls(2'h0, 1'b0, 3'h0, 1'b0, 6'h0, 3'h6, 1'b0, 2'h0, 3'h0, 1'b0);
		cls(2'h0, 1'b0, 3'h0, 1'b0, 6'h0, 3'h6, 1'b1, 2'h0, 3'h4, 1'b0);
		cls(2'h1, 1'b0, 3'h0, 1'b0, 6'h0, 3'h1, 1'b0, 2'h3, 3'h0, 1'b1);
		@(posedge ref_clk);
		stpCtrl[0] <= 3'h0;
		cls(2'h0, 1'b0, 3'h0, 1'b0, 6'h0, 3'h6, 1'b0, 2'h0, 3'h4, 1'b1);
		cls(2'h2, 1'b0, 3'h0, 1'b0, 6'h0, 3'h1, 1'b0, 2'h0, 3'h1, 1'b1);
		@(posedge ref_clk);
		stpCtrl[0] <= 3'h6;
		egress(2'h0, 1'b1, 1'b0, 1'b1, 1'b0);
		egress(2'h2, 1'b1, 1'b0, 1'b1, 1'b0);
		egress(2'h0, 1'b1, 1'b0, 1'b1, 1'b1);
		egress(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		slow <= 1'b1;
		egress(2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
		egress(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		test_done();
	end
endmodule
